// *** core/isolated_sensor_remote_command.sv ***
/*
 * remote command and response logic of the isolated sensor front-end:
 * link framing on the link clock, command decode and adc streaming on the
 * system clock, trim store and status over avalon-mm.
 * assumes the host frames the link as a sync pulse (both pins high), six
 * command slots, two idle slots and 38 device data slots per frame.
 */
// Design decisions made here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
`include "sensor_defs.svh"

module isolated_sensor_remote_command #(
    parameter logic [7:0] CHIP_VERSION = 8'h5a // arbitrary value
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_clk_link,
    input wire logic i_link_pos_pin,
    output logic o_link_pos_pin,
    output logic o_link_pos_pin_oe_n,
    input wire logic i_link_neg_pin,
    output logic o_link_neg_pin,
    output logic o_link_neg_pin_oe_n,
    input wire logic [21:0] i_adc_sample,
    input wire logic i_adc_valid,
    input wire logic [10:0] i_temp_reading,
    input wire logic [7:0] i_supply_reading,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic o_locked
);

    // ****************************************
    // link domain
    // ****************************************
    logic pos_s1_q, pos_s2_q, neg_s1_q, neg_s2_q;
    logic clr_s1_q, clr_s2_q, req_s1_q, req_s2_q, req_seen_q;
    logic cmd_tgl_q, drive_q;
    logic [5:0] slot_q;
    logic [4:0] cmd_sr_q;
    logic [37:0] shift_q;
    sensor_pkg::tx_payload_t payload_lk_q;
    sensor_pkg::remote_cmd_t cmd_lk_q;
    sensor_pkg::frame_state_t state_q;
    logic tick, lk_locked, lk_fast;
    // system-side state that the link side reads: soft_rst_q and req_q through synchronisers, payload_sys_q directly under the handshake
    logic [4:0] soft_rst_q;
    logic req_q;
    sensor_pkg::tx_payload_t payload_sys_q;

    // pin and cross-domain synchronisers on the link clock
    always_ff @(posedge i_clk_link or negedge i_reset_n) begin
        if (!i_reset_n) begin
            {pos_s1_q, pos_s2_q, neg_s1_q, neg_s2_q} <= 4'h0;
            {clr_s1_q, clr_s2_q, req_s1_q, req_s2_q} <= 4'h0;
        end else begin
            {pos_s1_q, pos_s2_q} <= {i_link_pos_pin, pos_s1_q};
            {neg_s1_q, neg_s2_q} <= {i_link_neg_pin, neg_s1_q};
            {clr_s1_q, clr_s2_q} <= {soft_rst_q != 5'h00, clr_s1_q};
            {req_s1_q, req_s2_q} <= {req_q, req_s1_q};
        end
    end

    pulse_lock u_lock (
        .i_clk_link(i_clk_link),
        .i_reset_n(i_reset_n),
        .i_clear(clr_s2_q),
        .i_pulse_level(pos_s2_q),
        .o_pulse_tick(tick),
        .o_locked(lk_locked),
        .o_fast(lk_fast)
    );

    // payload handshake: take the word when a new request arrives
    always_ff @(posedge i_clk_link or negedge i_reset_n) begin
        if (!i_reset_n) begin
            req_seen_q <= 1'b0;
            payload_lk_q <= '0;
        end else if (req_s2_q != req_seen_q) begin
            req_seen_q <= req_s2_q;
            payload_lk_q <= payload_sys_q;
        end
    end

    // frame walk driven by pulse ticks
    wire frame_sync = tick & neg_s2_q;
    wire [5:0] slot_nx = slot_q + 6'h01;
    always_ff @(posedge i_clk_link or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q <= sensor_pkg::FR_HUNT;
            slot_q <= 6'h00;
            cmd_sr_q <= 5'h00;
            cmd_lk_q <= '0;
            cmd_tgl_q <= 1'b0;
            shift_q <= '0;
            drive_q <= 1'b0;
        end else if (clr_s2_q || !lk_locked) begin
            state_q <= sensor_pkg::FR_HUNT;
            drive_q <= 1'b0;
        end else if (tick) begin
            case (state_q)
                sensor_pkg::FR_HUNT: begin
                    slot_q <= 6'h00;
                    if (frame_sync)
                        state_q <= sensor_pkg::FR_CMD;
                end
                sensor_pkg::FR_CMD: begin
                    cmd_sr_q <= {cmd_sr_q[3:0], neg_s2_q};
                    slot_q <= slot_nx;
                    if (slot_nx == `CMD_SLOTS) begin
                        cmd_lk_q <= {cmd_sr_q, neg_s2_q};
                        cmd_tgl_q <= ~cmd_tgl_q;
                        state_q <= sensor_pkg::FR_GAP;
                    end
                end
                sensor_pkg::FR_GAP: begin
                    slot_q <= slot_nx;
                    if (slot_nx == `TX_FIRST_SLOT) begin
                        shift_q <= payload_lk_q;
                        drive_q <= 1'b1;
                        state_q <= sensor_pkg::FR_SEND;
                    end
                end
                sensor_pkg::FR_SEND: begin
                    slot_q <= slot_nx;
                    shift_q <= {shift_q[36:0], 1'b0};
                    if (slot_q == `FRAME_SLOTS - 6'h01) begin
                        drive_q <= 1'b0;
                        state_q <= sensor_pkg::FR_HUNT;
                    end
                end
                default: state_q <= sensor_pkg::FR_HUNT;
            endcase
        end
    end

    // pins: positive line only listens, negative line carries device data
    assign o_link_pos_pin = 1'b0;
    assign o_link_pos_pin_oe_n = 1'b1;
    assign o_link_neg_pin = shift_q[37];
    assign o_link_neg_pin_oe_n = ~drive_q;

    // ****************************************
    // system domain: crossings
    // ****************************************
    logic lock_s1_q, lock_s2_q, fast_s1_q, fast_s2_q;
    logic ack_s1_q, ack_s2_q, cmd_s1_q, cmd_s2_q, cmd_s3_q;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            {lock_s1_q, lock_s2_q, fast_s1_q, fast_s2_q} <= 4'h0;
            {ack_s1_q, ack_s2_q, cmd_s1_q, cmd_s2_q, cmd_s3_q} <= 5'h00;
        end else begin
            {lock_s1_q, lock_s2_q} <= {lk_locked, lock_s1_q};
            {fast_s1_q, fast_s2_q} <= {lk_fast, fast_s1_q};
            {ack_s1_q, ack_s2_q} <= {req_seen_q, ack_s1_q};
            {cmd_s1_q, cmd_s2_q, cmd_s3_q} <= {cmd_tgl_q, cmd_s1_q, cmd_s2_q};
        end
    end

    // ****************************************
    // system domain: command decode
    // ****************************************
    logic [4:0] variant_q;
    logic [31:0] trim0_q;
    logic [9:0] trim1_q;
    logic [15:0] resp_q;
    logic [21:0] adc_hold_q;
    sensor_pkg::remote_cmd_t last_cmd_q;

    wire new_cmd = cmd_s2_q ^ cmd_s3_q;
    wire [2:0] code = cmd_lk_q.code;
    wire [1:0] sel = cmd_lk_q.sub[2:1];
    wire [7:0] temp_trim_value = variant_q[`VAR_TEMP] ? trim0_q[7:0] : 8'h00;
    wire [7:0] bandgap_trim_a = variant_q[`VAR_BG_A] ? trim0_q[15:8] : 8'h00;
    wire [7:0] bandgap_trim_b = variant_q[`VAR_BG_B] ? trim0_q[23:16] : 8'h00;
    wire [7:0] bandgap_trim_d = variant_q[`VAR_BG_D] ? trim0_q[31:24] : 8'h00;
    wire [9:0] bandgap_trim_c = variant_q[`VAR_BG_C] ? trim1_q : 10'h000;
    wire is_reset = (code == `CMD_RESET) && (cmd_lk_q.sub == `SUB_RESET);
    wire is_trim = (code == `CMD_TRIM);
    wire is_meas = (code == `CMD_MEAS) && (sel != `SEL_3);

    // response word per selector
    wire [15:0] trim_word = (sel == `SEL_0) ? {7'h00, temp_trim_value, 1'b0} :
                            (sel == `SEL_1) ? {bandgap_trim_c, 6'h00} :
                            (sel == `SEL_2) ? {bandgap_trim_a, 8'h00} :
                            {bandgap_trim_b, bandgap_trim_d};
    wire [15:0] meas_word = (sel == `SEL_0) ? {5'h00, i_temp_reading} :
                            (sel == `SEL_1) ? {8'h00, i_supply_reading} :
                            {CHIP_VERSION, 8'h00};
    wire [15:0] remote_response_word = is_trim ? trim_word : meas_word;
    wire busy = req_q != ack_s2_q;

    // response, reset and command record
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            resp_q <= 16'h0000;
            soft_rst_q <= 5'h00;
            last_cmd_q <= '0;
        end else if (soft_rst_q != 5'h00) begin
            soft_rst_q <= soft_rst_q - 5'h01;
            resp_q <= 16'h0000;
            last_cmd_q <= '0;
        end else if (new_cmd) begin
            if (is_reset) begin
                soft_rst_q <= `SOFT_RST_CYC;
            end else if (is_trim || is_meas) begin
                resp_q <= remote_response_word;
                last_cmd_q <= cmd_lk_q;
            end
        end
    end

    // adc capture and payload hand-over at each completed handshake
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            adc_hold_q <= 22'h000000;
            payload_sys_q <= '0;
            req_q <= 1'b0;
        end else begin
            if (soft_rst_q != 5'h00)
                adc_hold_q <= 22'h000000;
            else if (i_adc_valid)
                adc_hold_q <= i_adc_sample;
            if (!busy && lock_s2_q && soft_rst_q == 5'h00) begin
                payload_sys_q <= {adc_hold_q, resp_q};
                req_q <= ~req_q;
            end
        end
    end

    assign o_locked = lock_s2_q;

    // ****************************************
    // avalon-mm slave
    // ****************************************
    logic ack_q;
    logic [31:0] rdata_q;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b])
                res[b*8 +: 8] = nw[b*8 +: 8];
        end
        return res;
    endfunction : merge

    wire access = i_avs_read | i_avs_write;
    wire [1:0] index = i_avs_address[3:2];
    wire wr_go = i_avs_write & ack_q;
    wire [31:0] ctrl_merged = merge({27'h0, variant_q}, i_avs_writedata, i_avs_byteenable);
    wire [31:0] trim0_merged = merge(trim0_q, i_avs_writedata, i_avs_byteenable);
    wire [31:0] trim1_merged = merge({22'h0, trim1_q}, i_avs_writedata, i_avs_byteenable);
    wire [31:0] status_word = {23'h0, soft_rst_q != 5'h00, last_cmd_q.sub, last_cmd_q.code, fast_s2_q, lock_s2_q};
    wire [31:0] rd_mux = (index == `REG_CTRL) ? {27'h0, variant_q} :
                         (index == `REG_TRIM0) ? trim0_q :
                         (index == `REG_TRIM1) ? {22'h0, trim1_q} :
                         status_word;

    assign o_avs_waitrequest = access & ~ack_q;
    assign o_avs_readdata = rdata_q;

    // one wait cycle, then the access completes
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= access & ~ack_q;
            if (i_avs_read && !ack_q)
                rdata_q <= rd_mux;
        end
    end

    // trim store and variant mask; status is read only
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            variant_q <= `CTRL_RST;
            trim0_q <= `TRIM0_RST;
            trim1_q <= `TRIM1_RST;
        end else if (wr_go) begin
            if (index == `REG_CTRL)
                variant_q <= ctrl_merged[4:0];
            if (index == `REG_TRIM0)
                trim0_q <= trim0_merged;
            if (index == `REG_TRIM1)
                trim1_q <= trim1_merged[9:0];
        end
    end

endmodule : isolated_sensor_remote_command

// *** core/pulse_lock.sv ***
/*
 * lock detector for the link power pulses: measures the pulse period in
 * link clock cycles and declares lock after a run of matching periods.
 * assumes a pulse level already passed through two flip-flops.
 */
`timescale 1ns/100ps
`include "sensor_defs.svh"

module pulse_lock (
    input wire logic i_clk_link,
    input wire logic i_reset_n,
    input wire logic i_clear,
    input wire logic i_pulse_level,
    output logic o_pulse_tick,
    output logic o_locked,
    output logic o_fast
);

    logic prev_q;
    logic [7:0] cnt_q;
    logic [3:0] good_q;
    logic fast_q;
    logic locked_q;

    // period windows for both rates
    wire is_fast = (cnt_q >= 8'(`FAST_PERIOD_CYC - `PERIOD_TOL)) && (cnt_q <= 8'(`FAST_PERIOD_CYC + `PERIOD_TOL));
    wire is_slow = (cnt_q >= 8'(`SLOW_PERIOD_CYC - `PERIOD_TOL)) && (cnt_q <= 8'(`SLOW_PERIOD_CYC + `PERIOD_TOL));
    wire edge_seen = i_pulse_level & ~prev_q;
    wire match = (is_fast && fast_q) || (is_slow && !fast_q);

    assign o_pulse_tick = edge_seen;
    assign o_locked = locked_q;
    assign o_fast = fast_q;

    // period counter, saturates when pulses stop
    always_ff @(posedge i_clk_link or negedge i_reset_n) begin
        if (!i_reset_n) begin
            prev_q <= 1'b0;
            cnt_q <= 8'h00;
        end else begin
            prev_q <= i_pulse_level;
            if (i_clear || edge_seen)
                cnt_q <= 8'h01;
            else if (cnt_q != `CNT_MAX)
                cnt_q <= cnt_q + 8'h01;
        end
    end

    // lock at either rate after a run of equal periods
    always_ff @(posedge i_clk_link or negedge i_reset_n) begin
        if (!i_reset_n) begin
            good_q <= 4'h0;
            fast_q <= 1'b0;
            locked_q <= 1'b0;
        end else if (i_clear || cnt_q == `CNT_MAX) begin
            good_q <= 4'h0;
            locked_q <= 1'b0;
        end else if (edge_seen) begin
            if (match) begin
                if (good_q != `LOCK_COUNT)
                    good_q <= good_q + 4'h1;
                else
                    locked_q <= 1'b1;
            end else begin
                good_q <= 4'h0;
                locked_q <= 1'b0;
                fast_q <= is_fast;
            end
        end
    end

endmodule : pulse_lock

// *** core/sensor_defs.svh ***
/*
 * constants of the isolated sensor remote command block: command codes,
 * register map, reset values and link timing.
 * assumes inclusion by its bare name from any file that needs the values.
 */
`ifndef SENSOR_DEFS_SVH
`define SENSOR_DEFS_SVH

// ****************************************
// remote command codes
// ****************************************
`define CMD_TRIM 3'h1
`define CMD_MEAS 3'h2
`define CMD_RESET 3'h6
`define SUB_RESET 3'h7
`define SEL_0 2'h0
`define SEL_1 2'h1
`define SEL_2 2'h2
`define SEL_3 2'h3

// ****************************************
// register map (word index = byte address [3:2])
// ****************************************
`define REG_CTRL 2'h0
`define REG_TRIM0 2'h1
`define REG_TRIM1 2'h2
`define REG_STATUS 2'h3
`define CTRL_RST 5'h1f
`define TRIM0_RST 32'h0000_0000
`define TRIM1_RST 10'h000
`define VAR_TEMP 0
`define VAR_BG_A 1
`define VAR_BG_B 2
`define VAR_BG_C 3
`define VAR_BG_D 4

// ****************************************
// link timing, in picoseconds and link clock cycles
// ****************************************
`define LINK_CLK_PS 15000
`define FAST_PERIOD_PS 610350
`define SLOW_PERIOD_PS 1905000
`define FAST_PERIOD_CYC (`FAST_PERIOD_PS / `LINK_CLK_PS)
`define SLOW_PERIOD_CYC (`SLOW_PERIOD_PS / `LINK_CLK_PS)
`define PERIOD_TOL 2
`define LOCK_COUNT 4'h8
`define CNT_MAX 8'hff

// ****************************************
// frame layout, in pulse slots; soft reset length in system clock cycles
// ****************************************
`define CMD_SLOTS 6'h06
`define TX_FIRST_SLOT 6'h08
`define FRAME_SLOTS 6'h2e
`define SOFT_RST_CYC 5'h10

`endif

// *** core/sensor_pkg.sv ***
/*
 * types shared by the isolated sensor remote command block.
 * assumes nothing of its surroundings.
 */
package sensor_pkg;

    // command as received from the host in one frame
    typedef struct packed {
        logic [2:0] code;
        logic [2:0] sub;
    } remote_cmd_t;

    // word sent to the host in each frame: adc sample then response word
    typedef struct packed {
        logic [21:0] adc;
        logic [15:0] aux;
    } tx_payload_t;

    // frame walk of the link side, gray coded
    typedef enum logic [1:0] {
        FR_HUNT = 2'b00,
        FR_CMD = 2'b01,
        FR_GAP = 2'b11,
        FR_SEND = 2'b10
    } frame_state_t;

endpackage : sensor_pkg

// *** verification/host_link_model.sv ***
/* behavioural host at the far end of the pulse link: power pulses, frame
   sync, command bits and capture of the 38-bit device word.
   assumes the bench feeds o_neg to the block's data line input. */
`timescale 1ns/100ps
module host_link_model (
    input wire logic i_fast,
    input wire sensor_pkg::remote_cmd_t i_cmd,
    input wire logic i_neg_dev,
    input wire logic i_neg_dev_oe_n,
    output logic o_pos,
    output logic o_neg,
    output logic [37:0] o_rx_word,
    output int o_frames
);
logic host_en = 1'b1;
logic host_bit = 1'b0;
logic [5:0] cmd_bits = 6'h00;
logic [37:0] rx = 38'h0;
real per;
real wid;
// line level: device, else host; an undriven winding carries no pulse, so it reads low
assign o_neg = !i_neg_dev_oe_n ? i_neg_dev : (host_en ? host_bit : 1'b0);
// frame: sync, six command slots, two idle, 38 device slots, one spare
initial begin
    o_pos = 1'b0;
    o_frames = 0;
    o_rx_word = 38'h0;
    forever begin
        for (int k = 0; k < 48; k++) begin
            per = i_fast ? 610.35 : 1905.0;
            wid = i_fast ? 101.7 : 160.0;
            if (k >= 9 && k <= 46) rx = {rx[36:0], o_neg}; // device bits follow ticks 8 to 45
            if (k == 1) cmd_bits = i_cmd;
            host_en = (k < 9);
            host_bit = (k == 0) || (k >= 1 && k <= 6 && cmd_bits[6 - k]);
            #(per / 2.0);
            o_pos = 1'b1;
            #(wid);
            o_pos = 1'b0;
            #(per / 2.0 - wid);
        end
        o_rx_word = rx;
        o_frames++;
    end
end
endmodule : host_link_model

// *** verification/sensor_port_properties.sv ***
/* port checker of the remote command block.
   assumes a bind onto the block's top module. */
`timescale 1ns/100ps
module sensor_port_checker (
    input wire logic i_clk_sys,
    input wire logic i_clk_link,
    input wire logic i_reset_n,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic o_locked,
    input wire logic o_link_pos_pin_oe_n,
    input wire logic o_link_neg_pin_oe_n
);
// ********
// helper counters
// ********
logic [9:0] unlocked_q;
logic [12:0] drive_q;
// sys cycles spent unlocked, saturating
always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) unlocked_q <= 10'h000;
    else if (o_locked) unlocked_q <= 10'h000;
    else if (unlocked_q != 10'h3ff) unlocked_q <= unlocked_q + 10'h001;
end
// link cycles with the device on the data line
always_ff @(posedge i_clk_link or negedge i_reset_n) begin
    if (!i_reset_n) drive_q <= 13'h0000;
    else if (o_link_neg_pin_oe_n) drive_q <= 13'h0000;
    else if (drive_q != 13'h1fff) drive_q <= drive_q + 13'h0001;
end
// ********
// assertions
// ********
AST_POS_RELEASED: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    o_link_pos_pin_oe_n) else $error("pos line driven");
AST_WAIT_ONE: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    $rose(i_avs_read | i_avs_write) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("waitrequest not one cycle");
AST_IDLE_NO_WAIT: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    !(i_avs_read | i_avs_write) |-> !o_avs_waitrequest) else $error("waitrequest while idle");
AST_READ_STABLE: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    $changed(o_avs_readdata) |-> $past(i_avs_read & o_avs_waitrequest)) else $error("readdata moved");
AST_RESET_DEFAULTS: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    $rose(i_reset_n) |-> !o_locked && o_avs_readdata == 32'h0 && o_link_neg_pin_oe_n)
    else $error("outputs not at reset values");
AST_LOCK_TIME: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    $rose(o_locked) |-> unlocked_q >= 10'd400) else $error("lock too early");
AST_NO_DRIVE_UNLOCKED: assert property (@(posedge i_clk_link) disable iff (!i_reset_n)
    $fell(o_link_neg_pin_oe_n) |-> o_locked) else $error("drive while unlocked");
AST_DRIVE_BOUNDED: assert property (@(posedge i_clk_link) disable iff (!i_reset_n)
    drive_q <= 13'd5000) else $error("data line held too long");
endmodule : sensor_port_checker
bind isolated_sensor_remote_command sensor_port_checker chk (.i_clk_sys, .i_clk_link, .i_reset_n, .i_avs_read,
    .i_avs_write, .o_avs_readdata, .o_avs_waitrequest, .o_locked, .o_link_pos_pin_oe_n, .o_link_neg_pin_oe_n);

// *** verification/test_isolated_sensor_remote_command.sv ***
/* self-checking bench of the remote command block.
   assumes the host link model and the bound port checker. */
`timescale 1ns/100ps
module test_isolated_sensor_remote_command;
// ********
// signals
// ********
typedef struct packed {
    logic [4:0] ctrl;
    logic [5:0] cmd;
    logic [15:0] aux;
} row_t;
row_t rows [8] = '{
    '{5'h1f, 6'b001_000, 16'h0142},
    '{5'h1f, 6'b001_011, 16'hd780},
    '{5'h1f, 6'b001_100, 16'hb200},
    '{5'h1f, 6'b001_111, 16'hc3d4},
    '{5'h1e, 6'b001_001, 16'h0000},
    '{5'h1f, 6'b010_001, 16'h05a3},
    '{5'h1f, 6'b010_010, 16'h007e},
    '{5'h1f, 6'b010_101, 16'h5a00}};
logic clk = 1'b0, clk_link = 1'b0, rst_n = 1'b0, fast = 1'b0;
logic rd = 1'b0, we = 1'b0, adc_valid = 1'b0;
logic [3:0] addr = 4'h0;
logic [31:0] wdata = 32'h0, q, rdata;
logic [21:0] adc = 22'h0;
logic [10:0] temp = 11'h5a3;
logic [3:0] be = 4'hf;
logic waitreq, locked, pos, neg_line, dev_neg, dev_oe_n;
logic [37:0] rx_word;
sensor_pkg::remote_cmd_t cmd = '0;
sensor_pkg::tx_payload_t rx_w;
int frames, cyc = 0, n_errors = 0, n_compared = 0;
assign rx_w = rx_word;
always #5 clk = ~clk;
// link clock, unrelated in phase
initial begin
    #3.3;
    forever #7.5 clk_link = ~clk_link;
end
isolated_sensor_remote_command uut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_clk_link(clk_link),
    .i_link_pos_pin(pos), .o_link_pos_pin(), .o_link_pos_pin_oe_n(), .i_link_neg_pin(neg_line),
    .o_link_neg_pin(dev_neg), .o_link_neg_pin_oe_n(dev_oe_n), .i_adc_sample(adc), .i_adc_valid(adc_valid),
    .i_temp_reading(temp), .i_supply_reading(8'h7e), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(we), .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .o_locked(locked));
host_link_model host (.i_fast(fast), .i_cmd(cmd), .i_neg_dev(dev_neg), .i_neg_dev_oe_n(dev_oe_n),
    .o_pos(pos), .o_neg(neg_line), .o_rx_word(rx_word), .o_frames(frames));
// adc strobe every 32 cycles; limit covers three locks and about thirty fast frames
always @(posedge clk) begin
    cyc <= cyc + 1;
    adc_valid <= (cyc[4:0] == 5'h00);
    if (cyc == 90000) begin
        n_errors++;
        final_report();
    end
end
// ********
// tasks
// ********
task check(input logic [37:0] seen, input logic [37:0] exp);
    n_compared++;
    if (seen !== exp) begin
        n_errors++;
        $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
endtask : check
task avs(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !wr;
    we <= wr;
    addr <= a;
    wdata <= d;
    do @(posedge clk); while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    we <= 1'b0;
endtask : avs
task wait_frames(input int n);
    int f;
    f = frames + n;
    while (frames < f) @(posedge clk);
endtask : wait_frames
task wait_lock(input logic v);
    int n;
    n = 0;
    while (locked !== v && n < 30000) begin
        @(posedge clk);
        n++;
    end
endtask : wait_lock
task final_report;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
        $display("[ PASS ]");
    end else begin
        $display("[ FAIL ]");
    end
    $finish;
endtask : final_report
// ********
// main sequence
// ********
initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check(38'({locked, dev_oe_n, rdata}), 38'({1'b0, 1'b1, 32'h0}));
    $display("reset test done");
    wait_lock(1'b1);
    avs(1'b0, 4'hc, 32'h0);
    check(38'(q[1:0]), 38'h1);
    avs(1'b1, 4'h4, 32'hd4c3b2a1);
    avs(1'b1, 4'h8, 32'h0000035e);
    avs(1'b0, 4'h4, 32'h0);
    check(38'(q), 38'hd4c3b2a1);
    fast <= 1'b1;
    repeat (40) begin
        avs(1'b0, 4'hc, 32'h0);
        if (q[1:0] === 2'b11) break;
        repeat (100) @(posedge clk);
    end
    check(38'(q[1:0]), 38'h3);
    $display("lock test done");
    for (int i = 0; i < 8; i++) begin
        avs(1'b1, 4'h0, {27'h0, rows[i].ctrl});
        adc <= 22'h155000 + 22'(i);
        cmd <= rows[i].cmd;
        repeat (6) begin
            wait_frames(1);
            if (rx_w.aux === rows[i].aux) break;
        end
        check(38'(rx_w.aux), 38'(rows[i].aux));
        check(38'(rx_w.adc), 38'(22'h155000 + 22'(i)));
        $display("row %0d done", i);
    end
    be <= 4'h1;
    avs(1'b1, 4'h4, 32'h0000_00ee);
    be <= 4'hf;
    avs(1'b0, 4'h4, 32'h0);
    check(38'(q), 38'hd4c3b2ee);
    temp <= 11'h2c5;
    cmd <= 6'b010_000;
    repeat (6) begin
        wait_frames(1);
        if (rx_w.aux === 16'h02c5) break;
    end
    check(38'(rx_w.aux), 38'h02c5);
    $display("byte enable and sub-selector test done");
    cmd <= 6'b010_110;
    wait_frames(2);
    check(38'(rx_w.aux), 38'h02c5);
    cmd <= 6'b110_110;
    wait_frames(2);
    check(38'({locked, rx_w.aux}), 38'({1'b1, 16'h02c5}));
    $display("unlisted test done");
    cmd <= 6'b110_111;
    wait_lock(1'b0);
    check(38'(locked), 38'h0);
    cmd <= '0;
    wait_lock(1'b1);
    wait_frames(2);
    check(rx_word, {22'h155007, 16'h0000});
    $display("soft reset test done");
    final_report();
end
endmodule : test_isolated_sensor_remote_command
